/* verilog/psf_status_flags.sv */
// System status flag bank of the controller CPU with APB access
//
// Behaviour
// - Fatal error sets the fatal flag
// - Ordinary error sets the minor flag
// - Watchdog expiry sets the watchdog flag
// - I/O flag equals OR of fault bits
// - Low battery sets the battery flag
// - Open output fuse sets fuse flag
// - Backup flag high while backup normal
// - Clock setting error sets clock flag
// - Edit flag high during online editing
// - Failed online edit sets edit fault
`timescale 1ns/100ps
`include "psf_consts.svh"
module psf_status_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Conditions from the CPU
	input wire psf_pkg::psf_cond_t cond,
	input wire logic [31:0] io_fault_bits,
	// Flags and interrupt
	output psf_pkg::psf_flags_t status_flags,
	output logic irq
);
	import psf_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`PSF_STICKY_W-1:0] sticky_set;
	logic [`PSF_STICKY_W-1:0] sticky_q;
	psf_flags_t next_flags;
	logic [`PSF_WORD_W-1:0] next_word;
	logic [`PSF_WORD_W-1:0] cur_word;
	logic [`PSF_WORD_W-1:0] rise;
	logic [`PSF_WORD_W-1:0] irq_status;
	logic [`PSF_WORD_W-1:0] irq_enable;
	logic [`PSF_WORD_W-1:0] irq_clr;
	logic [31:0] io_fault;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic access;
	logic done;
	logic was_reset;

	// Pack a flag set into the status word layout
	function automatic logic [`PSF_WORD_W-1:0] pack_word(input psf_flags_t f);
		logic [`PSF_WORD_W-1:0] w;
		w = `PSF_RST_WORD;
		w[`PSF_POS_FATAL] = f.fatal_fault;
		w[`PSF_POS_MINOR] = f.minor_fault;
		w[`PSF_POS_WDOG] = f.watchdog_fault_flag;
		w[`PSF_POS_IO] = f.io_fault;
		w[`PSF_POS_BATT] = f.battery_low;
		w[`PSF_POS_FUSE] = f.fuse_fault;
		w[`PSF_POS_BACKUP] = f.backup_good;
		w[`PSF_POS_CLOCK] = f.clock_set_fault;
		w[`PSF_POS_EDIT_ACT] = f.edit_active;
		w[`PSF_POS_EDIT_ERR] = f.edit_fault;
		return w;
	endfunction : pack_word

	// ----------------------------------------
	// Error flags that stay set until power-up
	// ----------------------------------------
	// Event order: fatal, minor, watchdog, clock set, edit fail
	assign sticky_set = {cond.fatal_err, cond.minor_err, cond.wdog_expire,
		cond.rtc_set_err, cond.edit_fail};

	psf_sticky #(
		.WIDTH(`PSF_STICKY_W)
	) u_err_sticky (
		.clk(clk),
		.reset(reset),
		.set(sticky_set),
		.clr('0),
		.q(sticky_q)
	);

	// Next flag set, sticky errors merged with live levels
	always_comb begin
		next_flags = '0;
		next_flags.fatal_fault = sticky_q[4] | cond.fatal_err;
		next_flags.minor_fault = sticky_q[3] | cond.minor_err;
		next_flags.watchdog_fault_flag = sticky_q[2] | cond.wdog_expire;
		next_flags.io_fault = |io_fault_bits;
		next_flags.battery_low = cond.battery_low;
		next_flags.fuse_fault = cond.fuse_open;
		next_flags.backup_good = cond.backup_ok;
		next_flags.clock_set_fault = sticky_q[1] | cond.rtc_set_err;
		next_flags.edit_active = cond.edit_active;
		next_flags.edit_fault = sticky_q[0] | cond.edit_fail;
	end

	// Flag outputs, cleared at power-up
	always_ff @(posedge clk) begin
		if (reset) begin
			status_flags <= `PSF_RST_FLAGS;
		end else begin
			status_flags <= next_flags;
		end
	end

	// Copy of the individual I/O fault bits for software
	always_ff @(posedge clk) begin
		if (reset) begin
			io_fault <= `PSF_RST_IO_FAULT;
		end else begin
			io_fault <= io_fault_bits;
		end
	end

	// ----------------------------------------
	// Interrupt events on each flag going high
	// ----------------------------------------
	assign next_word = pack_word(next_flags);
	assign cur_word = pack_word(status_flags);
	assign rise = next_word & ~cur_word;
	assign irq_clr = (done && pwrite && paddr == `PSF_OFS_IRQ_CLEAR) ?
		pwdata[`PSF_WORD_W-1:0] : `PSF_RST_WORD;

	psf_sticky #(
		.WIDTH(`PSF_WORD_W)
	) u_irq_sticky (
		.clk(clk),
		.reset(reset),
		.set(rise),
		.clr(irq_clr),
		.q(irq_status)
	);

	// Interrupt enable register
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_enable <= `PSF_RST_WORD;
		end else if (done && pwrite && paddr == `PSF_OFS_IRQ_ENABLE) begin
			irq_enable <= pwdata[`PSF_WORD_W-1:0] & `PSF_USED_MASK;
		end
	end

	// Level interrupt from enabled pending events
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign access = psel & penable;
	assign done = access & pready;

	// Read mux and error decode
	always_comb begin
		next_prdata = `PSF_RST_PRDATA;
		next_pslverr = 1'b0;
		case (paddr)
			`PSF_OFS_STATUS: begin
				next_prdata[`PSF_WORD_W-1:0] = cur_word;
				next_pslverr = pwrite;
			end
			`PSF_OFS_IO_FAULT: begin
				next_prdata = io_fault;
				next_pslverr = pwrite;
			end
			`PSF_OFS_IRQ_STATUS: begin
				next_prdata[`PSF_WORD_W-1:0] = irq_status;
				next_pslverr = pwrite;
			end
			`PSF_OFS_IRQ_ENABLE: begin
				next_prdata[`PSF_WORD_W-1:0] = irq_enable;
			end
			`PSF_OFS_IRQ_CLEAR: begin
				next_prdata = `PSF_RST_PRDATA; // Write-only, reads zero
			end
			default: begin
				next_pslverr = 1'b1; // Unmapped
			end
		endcase
	end

	// One wait state, then the answer
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
		end else begin
			pready <= access & ~pready;
		end
	end

	// Read data and error, captured with pready
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= `PSF_RST_PRDATA;
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			prdata <= pwrite ? `PSF_RST_PRDATA : next_prdata;
			pslverr <= next_pslverr;
		end else begin
			prdata <= `PSF_RST_PRDATA;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Reset seen at the last edge; checks skip the release edge too
	always_ff @(posedge clk) begin
		was_reset <= reset;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset || was_reset);

	// Steps of a read of the status word
	sequence status_setup_s;
		psel && !penable && !pwrite && paddr == `PSF_OFS_STATUS;
	endsequence

	sequence status_access_s;
		psel && penable && !pwrite && paddr == `PSF_OFS_STATUS;
	endsequence

	// Steps of a write to the enable register
	sequence enable_setup_s;
		psel && !penable && pwrite && paddr == `PSF_OFS_IRQ_ENABLE;
	endsequence

	sequence enable_access_s;
		psel && penable && pwrite && paddr == `PSF_OFS_IRQ_ENABLE;
	endsequence

	fatal_flag_set_a: assert property (
		cond.fatal_err |=> status_flags.fatal_fault [*2])
		else $error("fatal flag not set or not held");

	minor_flag_set_a: assert property (
		cond.minor_err |=> status_flags.minor_fault ##1 status_flags.minor_fault)
		else $error("minor flag not set or not held");

	watchdog_flag_set_a: assert property (
		$rose(cond.wdog_expire) |=> status_flags.watchdog_fault_flag)
		else $error("watchdog flag not set");

	io_aggregate_a: assert property (
		!$past(reset) |-> status_flags.io_fault == (|$past(io_fault_bits)))
		else $error("I/O flag differs from fault bits");

	battery_flag_a: assert property (
		!$past(reset) |-> status_flags.battery_low == $past(cond.battery_low))
		else $error("battery flag does not follow monitor");

	fuse_flag_a: assert property (
		cond.fuse_open |=> status_flags.fuse_fault)
		else $error("fuse flag not set");

	backup_good_a: assert property (
		!cond.backup_ok |=> !status_flags.backup_good)
		else $error("backup flag high without normal backup");

	clock_flag_set_a: assert property (
		cond.rtc_set_err |=> status_flags.clock_set_fault)
		else $error("clock setting flag not set");

	edit_active_a: assert property (
		$fell(cond.edit_active) |=> !status_flags.edit_active)
		else $error("edit active flag not dropped");

	edit_fault_set_a: assert property (
		cond.edit_fail |=> status_flags.edit_fault)
		else $error("edit fault flag not set");

	sticky_hold_a: assert property (
		status_flags.fatal_fault |=> status_flags.fatal_fault)
		else $error("fatal flag cleared without reset");

	minor_hold_a: assert property (
		status_flags.minor_fault |=> status_flags.minor_fault)
		else $error("minor flag cleared without reset");

	watchdog_hold_a: assert property (
		status_flags.watchdog_fault_flag |=> status_flags.watchdog_fault_flag)
		else $error("watchdog flag cleared without reset");

	clock_hold_a: assert property (
		status_flags.clock_set_fault |=> status_flags.clock_set_fault)
		else $error("clock setting flag cleared without reset");

	edit_fault_hold_a: assert property (
		status_flags.edit_fault |=> status_flags.edit_fault)
		else $error("edit fault flag cleared without reset");

	status_read_a: assert property (
		status_setup_s ##1 status_access_s |=> pready && !pslverr &&
		(prdata[31:0] & ~{16'h0000, `PSF_USED_MASK}) == 32'h0000_0000)
		else $error("status read wrong or unused bits not zero");

	status_write_err_a: assert property (
		psel && penable && !pready && pwrite && paddr == `PSF_OFS_STATUS
		|=> pready && pslverr)
		else $error("write to read-only status not refused");

	irq_level_a: assert property (
		|(irq_status & irq_enable) |=> irq)
		else $error("interrupt not raised for enabled event");

	irq_low_a: assert property (
		!(|(irq_status & irq_enable)) |=> !irq)
		else $error("interrupt high with no enabled event");

	irq_clear_a: assert property (
		done && pwrite && paddr == `PSF_OFS_IRQ_CLEAR && rise == `PSF_RST_WORD
		|=> ({16'h0000, irq_status} & $past(pwdata)) == 32'h0000_0000)
		else $error("pending event not cleared by write");

	enable_write_a: assert property (
		enable_setup_s ##1 enable_access_s ##1 enable_access_s
		|=> {16'h0000, irq_enable} == ($past(pwdata) & {16'h0000, `PSF_USED_MASK}))
		else $error("enable register write not stored");

	pready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	answer_timing_a: assert property (
		psel && penable && !pready |=> pready)
		else $error("ready not given after one wait state");

	idle_bus_a: assert property (
		!pready |-> prdata == `PSF_RST_PRDATA && !pslverr)
		else $error("read data or error outside the answer cycle");

	unmapped_err_a: assert property (
		psel && penable && !pready && !(paddr inside {`PSF_OFS_STATUS, `PSF_OFS_IO_FAULT,
		`PSF_OFS_IRQ_STATUS, `PSF_OFS_IRQ_ENABLE, `PSF_OFS_IRQ_CLEAR})
		|=> pready && pslverr && prdata == `PSF_RST_PRDATA)
		else $error("unmapped access not refused or data not zero");

	flags_reset_a: assert property (
		$past(reset) |-> status_flags == `PSF_RST_FLAGS && !irq && !pready)
		else $error("outputs not cleared by reset");

endmodule : psf_status_flags

/* verilog/psf_consts.svh */
// Offsets, bit positions and reset values of the status flag bank
`ifndef PSF_CONSTS_SVH
`define PSF_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PSF_OFS_STATUS 8'h00
`define PSF_OFS_IO_FAULT 8'h04
`define PSF_OFS_IRQ_STATUS 8'h08
`define PSF_OFS_IRQ_ENABLE 8'h0c
`define PSF_OFS_IRQ_CLEAR 8'h10

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define PSF_POS_FATAL 0
`define PSF_POS_MINOR 1
`define PSF_POS_WDOG 2
`define PSF_POS_IO 3
`define PSF_POS_BATT 4
`define PSF_POS_FUSE 5
`define PSF_POS_BACKUP 9
`define PSF_POS_CLOCK 10
`define PSF_POS_EDIT_ACT 11
`define PSF_POS_EDIT_ERR 12

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define PSF_WORD_W 16
`define PSF_STICKY_W 5
`define PSF_USED_MASK 16'h1e3f
`define PSF_RST_FLAGS 10'h000
`define PSF_RST_WORD 16'h0000
`define PSF_RST_IO_FAULT 32'h0000_0000
`define PSF_RST_PRDATA 32'h0000_0000

`endif

/* verilog/psf_pkg.sv */
// Types shared by the status flag bank
package psf_pkg;

	// Conditions reported by the rest of the CPU
	typedef struct packed {
		logic fatal_err;
		logic minor_err;
		logic wdog_expire;
		logic rtc_set_err;
		logic edit_fail;
		logic battery_low;
		logic fuse_open;
		logic backup_ok;
		logic edit_active;
	} psf_cond_t;

	// Flag bank as seen by the user program
	typedef struct packed {
		logic fatal_fault;
		logic minor_fault;
		logic watchdog_fault_flag;
		logic io_fault;
		logic battery_low;
		logic fuse_fault;
		logic backup_good;
		logic clock_set_fault;
		logic edit_active;
		logic edit_fault;
	} psf_flags_t;

endpackage : psf_pkg

/* verilog/psf_sticky.sv */
// Per-bit sticky latch where a set beats a simultaneous clear
`timescale 1ns/100ps
module psf_sticky #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Set and clear strobes
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clr,
	// Latched bits
	output logic [WIDTH-1:0] q
);

	// ----------------------------------------
	// One latch per bit
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (reset) begin
					q[i] <= 1'b0;
				end else begin
					q[i] <= set[i] | (q[i] & ~clr[i]); // Set wins
				end
			end

			set_wins_a: assert property (@(posedge clk) disable iff (reset)
				!reset && set[i] |=> q[i])
				else $error("sticky bit lost a set");
		end
	endgenerate

endmodule : psf_sticky

/* test/psf_status_flags_test.sv */
// Self-checking bench of the status flag bank through its APB port
`timescale 1ns/100ps
`include "psf_consts.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); errors++; end end
module psf_status_flags_test;
	import psf_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	psf_cond_t cond = '0;
	logic [31:0] io_fault_bits = 32'h0000_0000;
	psf_flags_t status_flags;
	logic irq;
	int errors = 0;
	int tests_run = 0;
	int i;
	logic [31:0] exp_word;
	// Condition bit and status position of each sticky event
	int ev_bit[5] = '{8, 7, 6, 5, 4};
	int ev_pos[5] = '{`PSF_POS_FATAL, `PSF_POS_MINOR, `PSF_POS_WDOG, `PSF_POS_CLOCK,
		`PSF_POS_EDIT_ERR};
	// Condition bit and status position of each level flag
	int lv_bit[4] = '{3, 2, 1, 0};
	int lv_pos[4] = '{`PSF_POS_BATT, `PSF_POS_FUSE, `PSF_POS_BACKUP, `PSF_POS_EDIT_ACT};

	// Free running clock
	always #5 clk = ~clk;

	psf_status_flags psf_status_flags_inst (
		.clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cond(cond), .io_fault_bits(io_fault_bits),
		.status_flags(status_flags), .irq(irq)
	);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Verdict and end of run
	task end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// One APB transfer, waiting a bounded time for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			$display("CHECK FAILED pready expected 1 seen timeout");
			errors++;
			end_of_test();
		end
	endtask : apb

	// Read and compare data and error response
	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		`CHK("read data", exp, q)
		`CHK("read error", exp_err, e)
	endtask : rd_chk

	// Write and compare error response
	task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		`CHK("write error", exp_err, e)
	endtask : wr_chk

	// Let n edges pass, then stop where outputs are settled
	task cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : cyc

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		cyc(1);
		`CHK("flags after reset", 10'h000, status_flags)
		rd_chk(`PSF_OFS_STATUS, 32'h0000_0000, 1'b0);
		rd_chk(`PSF_OFS_IRQ_ENABLE, 32'h0000_0000, 1'b0);
		// Register access kinds and unmapped space
		wr_chk(`PSF_OFS_STATUS, 32'hffff_ffff, 1'b1);
		wr_chk(`PSF_OFS_IO_FAULT, 32'hffff_ffff, 1'b1);
		wr_chk(`PSF_OFS_IRQ_STATUS, 32'hffff_ffff, 1'b1);
		rd_chk(`PSF_OFS_STATUS, 32'h0000_0000, 1'b0);
		rd_chk(8'h20, 32'h0000_0000, 1'b1);
		wr_chk(8'h20, 32'hffff_ffff, 1'b1);
		rd_chk(`PSF_OFS_IRQ_CLEAR, 32'h0000_0000, 1'b0);
		wr_chk(`PSF_OFS_IRQ_ENABLE, 32'hffff_ffff, 1'b0);
		rd_chk(`PSF_OFS_IRQ_ENABLE, {16'h0000, `PSF_USED_MASK}, 1'b0);
		// Interrupt raised by a fatal error, then cleared
		wr_chk(`PSF_OFS_IRQ_ENABLE, 32'h0000_0001, 1'b0);
		cond[8] <= 1'b1;
		@(posedge clk);
		cond[8] <= 1'b0;
		cyc(3);
		`CHK("irq on fatal", 1'b1, irq)
		wr_chk(`PSF_OFS_IRQ_CLEAR, 32'h0000_0001, 1'b0);
		cyc(2);
		`CHK("irq after clear", 1'b0, irq)
		rd_chk(`PSF_OFS_IRQ_STATUS, 32'h0000_0000, 1'b0);
		// Masked minor error holds irq low until enabled
		cond[7] <= 1'b1;
		@(posedge clk);
		cond[7] <= 1'b0;
		cyc(3);
		`CHK("irq masked", 1'b0, irq)
		rd_chk(`PSF_OFS_IRQ_STATUS, 32'h0000_0002, 1'b0);
		wr_chk(`PSF_OFS_IRQ_ENABLE, 32'h0000_0002, 1'b0);
		cyc(2);
		`CHK("irq unmasked", 1'b1, irq)
		wr_chk(`PSF_OFS_IRQ_CLEAR, 32'h0000_0002, 1'b0);
		// Sticky error flags set by one-cycle events
		exp_word = 32'h0000_0003;
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			cond[ev_bit[i]] <= 1'b1;
			@(posedge clk);
			cond[ev_bit[i]] <= 1'b0;
			exp_word[ev_pos[i]] = 1'b1;
			cyc(2);
			rd_chk(`PSF_OFS_STATUS, exp_word, 1'b0);
		end
		// Level flags follow their conditions both ways
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			cond[lv_bit[i]] <= 1'b1;
			cyc(2);
			rd_chk(`PSF_OFS_STATUS, exp_word | (32'h1 << lv_pos[i]), 1'b0);
			@(posedge clk);
			cond[lv_bit[i]] <= 1'b0;
			cyc(2);
			rd_chk(`PSF_OFS_STATUS, exp_word, 1'b0);
		end
		// Aggregate I/O flag at both ends of the fault range
		io_fault_bits <= 32'h8000_0000;
		cyc(2);
		`CHK("io flag high", 1'b1, status_flags.io_fault)
		rd_chk(`PSF_OFS_IO_FAULT, 32'h8000_0000, 1'b0);
		io_fault_bits <= 32'h0000_0001;
		cyc(2);
		rd_chk(`PSF_OFS_STATUS, exp_word | 32'h0000_0008, 1'b0);
		io_fault_bits <= 32'h0000_0000;
		cyc(2);
		rd_chk(`PSF_OFS_STATUS, exp_word, 1'b0);
		// Second reset clears the sticky flags
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		cyc(1);
		`CHK("flags after second reset", 10'h000, status_flags)
		rd_chk(`PSF_OFS_STATUS, 32'h0000_0000, 1'b0);
		end_of_test();
	end

endmodule : psf_status_flags_test
